// ==== hdl/dde_engine.sv ====
// descriptor channel engine: AHB-Lite registers, chained descriptors,
// one byte per hub transfer; the hub completes a transfer on valid&ready
// assumes the hub holds ready low while the processor owns the spoke
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`include "dde_defs.svh"

module dde_engine #(
	parameter int NCH = 24,
	parameter int NTD = 128
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// channel requests and completion
	input wire logic [NCH-1:0] drq,
	input wire logic [NCH-1:0] terminate_in,
	output logic [NCH-1:0] done_pulse,
	// peripheral bus hub master
	input wire logic cpu_spoke_req,
	output logic dm_valid,
	output logic dm_write,
	output logic [31:0] dm_addr,
	output logic [7:0] dm_wdata,
	input wire logic dm_ready,
	input wire logic [7:0] dm_rdata
);

	localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

	typedef struct packed {
		dde_pkg::dde_chcfg_t [NCH-1:0] cfg;
		logic [NCH-1:0] pend;
		logic [NCH-1:0] chon;
		logic [NCH-1:0] drq_p;
		logic [NCH-1:0] term_p;
		logic [NCH-1:0] done_v;
		logic [NCH-1:0][7:0] cur;
		dde_pkg::dde_state_t st;
		logic [CW-1:0] ch;
		logic [7:0] tdi;
		dde_pkg::dde_td_t td;
		logic [6:0] blen;
		logic [6:0] pos;
		logic term_hit;
		logic [7:0] rbyte;
		logic [1:0] done_cnt;
		logic dm_valid;
		logic dm_write;
		logic [31:0] dm_addr;
		logic [7:0] dm_wdata;
		logic d_wr;
		logic d_rd;
		logic [11:0] d_addr;
		logic hready;
		logic hresp;
		logic [31:0] hrdata;
	} dde_st_t;

	dde_st_t s_q;
	dde_st_t s_d;
	dde_pkg::dde_td_t mem_rd;
	dde_pkg::dde_chcfg_t cur_cfg;
	logic [NCH-1:0] arb_req;
	logic [NCH-1:0][2:0] arb_prio;
	logic arb_any;
	logic [CW-1:0] arb_pick;
	logic mem_a_we;

	// ****************************************
	// helpers
	// ****************************************
	// a zero burst setting would never finish, so it moves one byte
	function automatic logic [6:0] burst_len(input logic [6:0] b,
			input logic [11:0] rem);
		logic [6:0] n;
		n = (b == 7'h00) ? 7'h01 : b;
		burst_len = (rem < 12'(n)) ? rem[6:0] : n;
	endfunction

	// xor reverses the byte within an aligned group
	function automatic logic [6:0] swap_off(input logic [6:0] p,
			input logic en, input logic four);
		if (!en)
			swap_off = p;
		else if (four)
			swap_off = p ^ `DDE_SWAP4_MASK;
		else
			swap_off = p ^ `DDE_SWAP2_MASK;
	endfunction

	// ****************************************
	// submodules
	// ****************************************
	assign cur_cfg = s_q.cfg[s_q.ch];
	assign mem_a_we = s_q.d_wr &&
		((s_q.d_addr & `DDE_TD_MASK) == `DDE_TD_BASE);

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			arb_req[i] = s_q.pend[i] && s_q.chon[i] && s_q.cfg[i].en;
			arb_prio[i] = s_q.cfg[i].prio;
		end
	end

	dde_arb #(.NCH(NCH), .CW(CW)) u_arb (
		.req(arb_req),
		.prio(arb_prio),
		.any(arb_any),
		.pick(arb_pick)
	);

	dde_td_mem #(.NTD(NTD)) u_mem (
		.hclk(hclk),
		.hresetn(hresetn),
		.a_we(mem_a_we),
		.a_idx({1'b0, s_q.d_addr[9:3]}),
		.a_hi(s_q.d_addr[2]),
		.a_data(hwdata),
		.b_we((s_q.st == dde_pkg::ST_DONE) &&
			!cur_cfg.keep_descriptor),
		.b_idx(s_q.tdi),
		.b_data(s_q.td),
		.r_idx(s_q.tdi),
		.r_data(mem_rd)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		dde_pkg::dde_chcfg_t nc;
		logic [NCH-1:0] edge_r;
		logic [NCH-1:0] term_r;
		logic [NCH-1:0] swset;
		logic [NCH-1:0] en_v;
		logic acc;
		logic [11:0] a;
		logic [CW-1:0] ci;
		logic in_ch;
		logic [11:0] left;
		nc = '0;
		swset = '0;
		en_v = '0;
		s_d = s_q;
		acc = s_q.dm_valid && dm_ready;
		edge_r = drq & ~s_q.drq_p;
		term_r = terminate_in & ~s_q.term_p;
		a = s_q.d_addr;
		ci = CW'(a[11:3]);
		in_ch = a < 12'(NCH * 8);
		left = s_q.td.count - 12'(s_q.pos);
		s_d.drq_p = drq;
		s_d.term_p = terminate_in;

		if (s_q.done_cnt != 2'h0) begin
			s_d.done_cnt = s_q.done_cnt - 2'h1;
			if (s_q.done_cnt == 2'h1)
				s_d.done_v = '0;
		end

		case (s_q.st)
			dde_pkg::ST_IDLE: begin
				if (arb_any) begin
					s_d.ch = arb_pick;
					s_d.tdi = s_q.cur[arb_pick];
					s_d.pend[arb_pick] = 1'b0;
					s_d.st = dde_pkg::ST_FETCH;
				end
			end
			dde_pkg::ST_FETCH: s_d.st = dde_pkg::ST_LOAD;
			dde_pkg::ST_LOAD: begin
				s_d.td = mem_rd;
				if (mem_rd.count == 12'h000)
					s_d.st = dde_pkg::ST_DONE;
				else
					s_d.st = dde_pkg::ST_SETUP;
			end
			dde_pkg::ST_SETUP: begin
				s_d.blen = burst_len(cur_cfg.burst, s_q.td.count);
				s_d.pos = 7'h00;
				s_d.term_hit = 1'b0;
				s_d.st = dde_pkg::ST_RD;
			end
			dde_pkg::ST_RD, dde_pkg::ST_WR: begin
				// the terminate edge only counts while a burst runs
				if (s_q.td.terminate_in_enable_flag && term_r[s_q.ch])
					s_d.term_hit = 1'b1;
				if (acc) begin
					s_d.dm_valid = 1'b0;
					if (s_q.st == dde_pkg::ST_RD) begin
						s_d.rbyte = dm_rdata;
						if (s_q.td.source_increment_flag)
							s_d.td.src = s_q.td.src + 16'h0001;
						s_d.st = dde_pkg::ST_WR;
					end else begin
						s_d.pos = s_q.pos + 7'h01;
						if (s_q.pos + 7'h01 == s_q.blen || s_d.term_hit)
							s_d.st = dde_pkg::ST_NEXT;
						else
							s_d.st = dde_pkg::ST_RD;
					end
				end else if (cpu_spoke_req) begin
					s_d.dm_valid = 1'b0;
				end else if (!s_q.dm_valid) begin
					s_d.dm_valid = 1'b1;
					s_d.dm_write = (s_q.st == dde_pkg::ST_WR);
					s_d.dm_wdata = s_q.rbyte;
					if (s_q.st == dde_pkg::ST_RD)
						s_d.dm_addr = {cur_cfg.src_hi, s_q.td.src};
					else if (s_q.td.dest_increment_flag)
						s_d.dm_addr = {cur_cfg.dst_hi, s_q.td.dst +
							16'(swap_off(s_q.pos, s_q.td.swap_enable_flag,
							s_q.td.swap_four_byte_flag))};
					else
						s_d.dm_addr = {cur_cfg.dst_hi, s_q.td.dst};
				end
			end
			dde_pkg::ST_NEXT: begin
				s_d.td.count = left;
				if (s_q.td.dest_increment_flag)
					s_d.td.dst = s_q.td.dst + 16'(s_q.pos);
				if (left == 12'h000 || s_q.term_hit)
					s_d.st = dde_pkg::ST_DONE;
				else if (cur_cfg.per_burst)
					s_d.st = dde_pkg::ST_WAIT;
				else
					s_d.st = dde_pkg::ST_SETUP;
			end
			dde_pkg::ST_WAIT: begin
				if (!cur_cfg.en) begin
					s_d.st = dde_pkg::ST_IDLE;
				end else if (s_q.pend[s_q.ch]) begin
					s_d.pend[s_q.ch] = 1'b0;
					s_d.st = dde_pkg::ST_SETUP;
				end
			end
			dde_pkg::ST_DONE: begin
				if (s_q.td.done_pulse_enable_flag) begin
					s_d.done_v = '0;
					s_d.done_v[s_q.ch] = 1'b1;
					s_d.done_cnt = `DDE_DONE_CYCLES;
				end
				s_d.st = dde_pkg::ST_IDLE;
				if (s_q.td.next == `DDE_CHAIN_END) begin
					s_d.chon[s_q.ch] = 1'b0;
				end else begin
					s_d.cur[s_q.ch] = s_q.td.next;
					if (s_q.td.auto_advance_flag) begin
						s_d.tdi = s_q.td.next;
						s_d.st = dde_pkg::ST_FETCH;
					end
				end
			end
			default: s_d.st = dde_pkg::ST_IDLE;
		endcase

		// bus data phase: writes with zero wait, reads after one wait
		if (s_q.d_wr) begin
			if (in_ch && a[2]) begin
				s_d.cfg[ci][63:32] = hwdata;
			end else if (in_ch) begin
				nc = {s_q.cfg[ci][63:32], hwdata & `DDE_CFG_MASK};
				if (nc.en && !s_q.cfg[ci].en) begin
					s_d.chon[ci] = 1'b1;
					s_d.cur[ci] = nc.init_td;
				end
				s_d.cfg[ci] = nc;
			end else if (a == `DDE_SWREQ_OFS) begin
				swset = hwdata[NCH-1:0];
			end
		end
		if (s_q.d_rd) begin
			s_d.d_rd = 1'b0;
			s_d.hready = 1'b1;
			if (in_ch && a[2])
				s_d.hrdata = s_q.cfg[ci][63:32];
			else if (in_ch)
				s_d.hrdata = s_q.cfg[ci][31:0];
			else if (a == `DDE_SWREQ_OFS)
				s_d.hrdata = 32'(s_q.pend);
			else if (a == `DDE_STATUS_OFS)
				s_d.hrdata = {8'h00, 8'(s_q.ch), s_q.tdi, 4'h0, s_q.st};
			else
				s_d.hrdata = 32'h00000000;
		end

		// bus address phase; only whole words are taken
		s_d.d_wr = 1'b0;
		if (hsel && hready && htrans[1] && hsize == 3'h2) begin
			s_d.d_addr = haddr[11:0];
			s_d.d_wr = hwrite;
			s_d.d_rd = !hwrite;
			s_d.hready = hwrite;
		end

		// a new request beats the clear of the same cycle
		for (int i = 0; i < NCH; i++)
			en_v[i] = s_d.cfg[i].en;
		s_d.pend = (s_d.pend | edge_r | swset) & en_v;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
			s_q.hready <= 1'b1;
			for (int i = 0; i < NCH; i++)
				s_q.cfg[i] <= {32'h00000000, `DDE_CFG_RESET};
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign hreadyout = s_q.hready;
	assign hresp = s_q.hresp;
	assign hrdata = s_q.hrdata;
	assign done_pulse = s_q.done_v;
	assign dm_valid = s_q.dm_valid;
	assign dm_write = s_q.dm_write;
	assign dm_addr = s_q.dm_addr;
	assign dm_wdata = s_q.dm_wdata;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_two_high;
		(|s_q.done_v) ##1 (|s_q.done_v) ##1 !(|s_q.done_v);
	endsequence

	a_done_width: assert property (
		$rose(|s_q.done_v) |-> s_two_high)
		else $error("done pulse not two cycles");
	a_done_gate: assert property (
		(s_q.st == dde_pkg::ST_DONE) |=>
		((|s_q.done_v) == $past(s_q.td.done_pulse_enable_flag)))
		else $error("done pulse does not follow its flag");
	a_addr_join: assert property (
		s_q.dm_valid |-> s_q.dm_addr[31:16] ==
		(s_q.dm_write ? cur_cfg.dst_hi : cur_cfg.src_hi))
		else $error("upper address half wrong");
	a_burst_trim: assert property (
		(s_q.st == dde_pkg::ST_SETUP && cur_cfg.burst != 7'h00) |=>
		(s_q.blen == ((s_q.td.count < 12'(cur_cfg.burst)) ?
		s_q.td.count[6:0] : cur_cfg.burst)))
		else $error("burst length not trimmed");
	a_count_step: assert property (
		(s_q.st == dde_pkg::ST_NEXT) |=> s_q.td.count ==
		$past(s_q.td.count) - 12'($past(s_q.pos)))
		else $error("remaining count not reduced by burst");
	a_chain_stop: assert property (
		(s_q.st == dde_pkg::ST_DONE && s_q.td.next == `DDE_CHAIN_END) |=>
		(s_q.st == dde_pkg::ST_IDLE && !s_q.chon[$past(s_q.ch)]))
		else $error("chain did not stop at end index");
	a_auto_fetch: assert property (
		(s_q.st == dde_pkg::ST_DONE && s_q.td.auto_advance_flag &&
		s_q.td.next != `DDE_CHAIN_END) |=>
		(s_q.st == dde_pkg::ST_FETCH && s_q.tdi == $past(s_q.td.next)))
		else $error("linked descriptor not started");
	a_cpu_wins: assert property (
		cpu_spoke_req |=> !s_q.dm_valid)
		else $error("engine drives spoke against processor");
	a_src_step: assert property (
		(s_q.st == dde_pkg::ST_RD && s_q.dm_valid && dm_ready) |=>
		s_q.td.src == $past(s_q.td.src) +
		($past(s_q.td.source_increment_flag) ? 16'h0001 : 16'h0000))
		else $error("source address step wrong");
	a_start_en: assert property (
		(s_q.st == dde_pkg::ST_IDLE && arb_any) |=>
		s_q.cfg[s_q.ch].en && s_q.st == dde_pkg::ST_FETCH)
		else $error("disabled channel started");

endmodule

// ==== hdl/dde_defs.svh ====
// offsets, reset values and counts of the descriptor channel engine
// assumes a 12-bit register window decoded from the low address bits
`ifndef DDE_DEFS_SVH
`define DDE_DEFS_SVH

// ****************************************
// register map
// ****************************************
`define DDE_CH_STRIDE 12'h008
`define DDE_SWREQ_OFS 12'h100
`define DDE_STATUS_OFS 12'h104
`define DDE_TD_BASE 12'h400
`define DDE_TD_MASK 12'hC00

// ****************************************
// fields and reset values
// ****************************************
`define DDE_CFG_MASK 32'hFF007F77
`define DDE_CFG_RESET 32'h00000100
`define DDE_CHAIN_END 8'hFE
`define DDE_SWAP2_MASK 7'h01
`define DDE_SWAP4_MASK 7'h03

// ****************************************
// timing
// ****************************************
`define DDE_DONE_CYCLES 2'h2

`endif

// ==== hdl/dde_pkg.sv ====
// types shared by the descriptor channel engine and its memory
// assumes nothing beyond a SystemVerilog compiler
package dde_pkg;

	// ****************************************
	// transfer descriptor, two bus words
	// ****************************************
	typedef struct packed {
		logic [15:0] dst;
		logic [15:0] src;
		logic [4:0] pad;
		logic swap_enable_flag;
		logic swap_four_byte_flag;
		logic auto_advance_flag;
		logic terminate_in_enable_flag;
		logic done_pulse_enable_flag;
		logic dest_increment_flag;
		logic source_increment_flag;
		logic [7:0] next;
		logic [11:0] count;
	} dde_td_t;

	// ****************************************
	// channel configuration, two bus words
	// ****************************************
	typedef struct packed {
		logic [15:0] dst_hi;
		logic [15:0] src_hi;
		logic [7:0] init_td;
		logic [8:0] pad9;
		logic [6:0] burst;
		logic pad1;
		logic [2:0] prio;
		logic pad0;
		logic keep_descriptor;
		logic per_burst;
		logic en;
	} dde_chcfg_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_FETCH = 4'h1,
		ST_LOAD = 4'h2,
		ST_SETUP = 4'h3,
		ST_RD = 4'h4,
		ST_WR = 4'h5,
		ST_NEXT = 4'h6,
		ST_WAIT = 4'h7,
		ST_DONE = 4'h8
	} dde_state_t;

endpackage

// ==== hdl/dde_td_mem.sv ====
// descriptor store: word writes from software, whole-entry write-back
// assumes indices below NTD; read data appear one clock after the index
module dde_td_mem #(
	parameter int NTD = 128
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// software word write
	input wire logic a_we,
	input wire logic [7:0] a_idx,
	input wire logic a_hi,
	input wire logic [31:0] a_data,
	// engine write-back
	input wire logic b_we,
	input wire logic [7:0] b_idx,
	input wire dde_pkg::dde_td_t b_data,
	// registered read
	input wire logic [7:0] r_idx,
	output dde_pkg::dde_td_t r_data
);

	typedef struct packed {
		dde_pkg::dde_td_t [NTD-1:0] mem;
		dde_pkg::dde_td_t rd;
	} dde_mem_st_t;

	dde_mem_st_t s_q;
	dde_mem_st_t s_d;

	// engine write-back lands last so it wins a collision
	always_comb begin
		s_d = s_q;
		if (a_we) begin
			if (a_hi)
				s_d.mem[a_idx][63:32] = a_data;
			else
				s_d.mem[a_idx][31:0] = a_data;
		end
		if (b_we)
			s_d.mem[b_idx] = b_data;
		s_d.rd = s_q.mem[r_idx];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign r_data = s_q.rd;

endmodule

// ==== hdl/dde_arb.sv ====
// picks the pending channel with the best priority level
// level 0 is best; ties go to the lowest channel number
module dde_arb #(
	parameter int NCH = 24,
	parameter int CW = 5
) (
	// candidates
	input wire logic [NCH-1:0] req,
	input wire logic [NCH-1:0][2:0] prio,
	// choice
	output logic any,
	output logic [CW-1:0] pick
);

	always_comb begin
		logic [2:0] best;
		best = 3'h7;
		any = 1'b0;
		pick = '0;
		for (int i = 0; i < NCH; i++) begin
			if (req[i] && (!any || prio[i] < best)) begin
				any = 1'b1;
				best = prio[i];
				pick = CW'(i);
			end
		end
	end

endmodule

// ==== tb/dde_hub_model.sv ====
// hub model: byte-wide bus hub answering the engine's transfers
// assumes one outstanding transfer; read data is the low address byte
module dde_hub_model (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// engine side
	input wire logic dm_valid,
	input wire logic [31:0] dm_addr,
	input wire logic cpu_spoke_req,
	input wire logic [1:0] lat,
	output logic dm_ready,
	output logic [7:0] dm_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt_q;

	// ********
	// answer after lat waiting cycles
	// ********
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dm_ready <= 1'b0;
			cnt_q <= 2'h0;
			dm_rdata <= 8'hA5;
		end else if (dm_valid && dm_ready) begin
			dm_ready <= 1'b0;
			cnt_q <= 2'h0;
			// released line shows the inverse, so stale data never matches
			dm_rdata <= ~dm_rdata;
		end else if (dm_valid && !cpu_spoke_req) begin
			if (cnt_q == lat) begin
				dm_ready <= 1'b1;
				dm_rdata <= dm_addr[7:0];
			end else begin
				cnt_q <= cnt_q + 2'h1;
			end
		end else begin
			dm_ready <= 1'b0;
			cnt_q <= 2'h0;
		end
	end
endmodule

// ==== tb/test_dde_engine.sv ====
// bench for the descriptor channel engine on channel 0
// assumes the hub model answers every transfer; one clock domain
`include "dde_defs.svh"
module test_dde_engine;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int NCH = 24;
	localparam logic [15:0] SHI = 16'h2000;
	localparam logic [15:0] SLO = 16'h0010;
	localparam logic [15:0] DHI = 16'h3000;
	localparam logic [15:0] DLO = 16'h0200;
	typedef struct packed {
		logic [11:0] cnt;
		logic [6:0] f;
		logic [6:0] burst;
		logic [1:0] lat;
	} dde_row_t;
	// flags: swap, swap4, auto, term, done, dst inc, src inc
	// bursts stay multiples of the swap group
	dde_row_t rows[6] = '{
		'{12'h003, 7'h07, 7'h01, 2'h0},
		'{12'h004, 7'h47, 7'h02, 2'h2},
		'{12'h008, 7'h67, 7'h04, 2'h1},
		'{12'h005, 7'h07, 7'h04, 2'h0},
		'{12'h002, 7'h00, 7'h01, 2'h3},
		'{12'h000, 7'h04, 7'h01, 2'h0}
	};
	logic hclk, hresetn, hsel, hwrite, hready, hresp, cpu;
	logic [31:0] haddr, hwdata, hrdata, rd, dm_addr;
	logic [1:0] htrans, lat;
	logic [2:0] hsize;
	logic [NCH-1:0] drq, term, done_pulse;
	logic dm_valid, dm_write, dm_ready;
	logic [7:0] dm_wdata, dm_rdata;
	logic [31:0] wa[$];
	logic [7:0] wd[$];
	int miscompares, n_compared, cyc, dcnt, p;

	dde_engine #(.NCH(NCH)) u_dde_engine (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .drq(drq),
		.terminate_in(term), .done_pulse(done_pulse),
		.cpu_spoke_req(cpu), .dm_valid(dm_valid), .dm_write(dm_write),
		.dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_ready(dm_ready),
		.dm_rdata(dm_rdata));
	dde_hub_model u_dde_hub_model (.hclk(hclk), .hresetn(hresetn),
		.dm_valid(dm_valid), .dm_addr(dm_addr), .cpu_spoke_req(cpu),
		.lat(lat), .dm_ready(dm_ready), .dm_rdata(dm_rdata));

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	// ********
	// hub write log, pulse count, hang guard
	// ********
	always @(posedge hclk) begin
		if (dm_valid && dm_ready && dm_write) begin
			wa.push_back(dm_addr);
			wd.push_back(dm_wdata);
		end
		if (done_pulse[0] === 1'b1)
			dcnt++;
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// single word transfer; called just after a rising edge
	task automatic ahb(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic td(input int t, input logic [11:0] c,
		input logic [7:0] nx, input logic [6:0] f);
		ahb(1'b1, 32'(32'h400 + t * 8), {5'h0, f, nx, c});
		ahb(1'b1, 32'(32'h404 + t * 8), {DLO, SLO});
	endtask

	// disable then enable when en is set, so such a call restarts at the initial entry
	task automatic chan(input logic [6:0] b, input logic pb,
		input logic [7:0] it, input logic en);
		ahb(1'b1, 32'h4, {DHI, SHI});
		ahb(1'b1, 32'h0, {it, 9'h0, b, 8'h0});
		ahb(1'b1, 32'h0, {it, 9'h0, b, 5'h0, 1'b0, pb, en});
		wa.delete();
		wd.delete();
		dcnt = 0;
	endtask

	task automatic go(input int n);
		for (int i = 0; i < 3000 && wa.size() < n; i++) @(posedge hclk);
		repeat (30) @(posedge hclk);
	endtask

	task automatic pulse_drq();
		drq[0] <= 1'b1;
		@(posedge hclk);
		drq[0] <= 1'b0;
		@(posedge hclk);
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		drq = '0;
		term = '0;
		cpu = 1'b0;
		lat = 2'h0;
		miscompares = 0;
		n_compared = 0;
		cyc = 0;
		dcnt = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rows[i]) begin
			lat <= rows[i].lat;
			td(0, rows[i].cnt, `DDE_CHAIN_END, rows[i].f);
			chan(rows[i].burst, 1'b0, 8'h00, 1'b1);
			ahb(1'b1, `DDE_SWREQ_OFS, 32'h1);
			go(rows[i].cnt);
			chk(32'(wa.size()), {20'h0, rows[i].cnt});
			if (wa.size() == rows[i].cnt) begin
				for (int k = 0; k < rows[i].cnt; k++) begin
					p = k;
					if (rows[i].f[6] && rows[i].f[1])
						p = k ^ (rows[i].f[5] ? 3 : 1);
					chk(wa[k], {DHI, DLO + (rows[i].f[1] ? p[15:0] : 16'h0)});
					chk({24'h0, wd[k]}, {24'h0, SLO[7:0] + (rows[i].f[0] ? k[7:0] : 8'h0)});
				end
			end
			chk(32'(dcnt), rows[i].f[2] ? 32'h2 : 32'h0);
		end
		// second reset in mid-run, then the register map
		hresetn <= 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk(32'h0, `DDE_CFG_RESET);
		rdchk(`DDE_STATUS_OFS, 32'h0);
		rdchk(32'h200, 32'h0);
		ahb(1'b1, 32'h0, 32'hFFFFFFFE);
		rdchk(32'h0, 32'hFFFFFFFE & `DDE_CFG_MASK);
		rdchk(32'h400, 32'h0);
		// chain of two from entry 1; entry 0 holds a zero count
		lat <= 2'h1;
		td(1, 12'h002, 8'h02, 7'h17);
		td(2, 12'h001, `DDE_CHAIN_END, 7'h07);
		chan(7'h01, 1'b0, 8'h01, 1'b1);
		ahb(1'b1, `DDE_SWREQ_OFS, 32'h1);
		// processor holds the spoke: the engine must stay off it
		cpu <= 1'b1;
		repeat (20) @(posedge hclk);
		chk({31'h0, dm_valid}, 32'h0);
		chk(32'(wa.size()), 32'h0);
		cpu <= 1'b0;
		go(3);
		chk(32'(wa.size()), 32'h3);
		chk(32'(dcnt), 32'h4);
		// one hardware request per burst
		td(0, 12'h003, `DDE_CHAIN_END, 7'h07);
		chan(7'h01, 1'b1, 8'h00, 1'b1);
		for (int n = 1; n <= 3; n++) begin
			pulse_drq();
			go(n);
			chk(32'(wa.size()), 32'(n));
		end
		// keep option: the same entry runs twice unchanged
		td(0, 12'h002, `DDE_CHAIN_END, 7'h03);
		repeat (2) begin
			chan(7'h01, 1'b0, 8'h00, 1'b0);
			ahb(1'b1, 32'h0, 32'h00000105);
			ahb(1'b1, `DDE_SWREQ_OFS, 32'h1);
			go(2);
			chk(32'(wa.size()), 32'h2);
			chk(32'(dcnt), 32'h0);
		end
		// terminate edge in the middle of one long burst
		td(0, 12'h040, `DDE_CHAIN_END, 7'h0F);
		chan(7'h40, 1'b0, 8'h00, 1'b1);
		ahb(1'b1, `DDE_SWREQ_OFS, 32'h1);
		for (int i = 0; i < 3000 &&
			!(dm_valid && dm_ready && dm_write); i++)
			@(posedge hclk);
		term[0] <= 1'b1;
		go(2);
		term[0] <= 1'b0;
		chk(32'(wa.size()), 32'h2);
		chk(32'(dcnt), 32'h2);
		// disabled channel ignores both kinds of request
		// enable first so the chain is live when it is switched off
		chan(7'h01, 1'b0, 8'h00, 1'b1);
		chan(7'h01, 1'b0, 8'h00, 1'b0);
		ahb(1'b1, `DDE_SWREQ_OFS, 32'h1);
		pulse_drq();
		repeat (60) @(posedge hclk);
		chk(32'(wa.size()), 32'h0);
		chk(32'(dcnt), 32'h0);
		tally_and_finish();
	end
endmodule
